/* File: ctf_ctrl.sv */
// Functional notes
// - Normal mode drives transmit level onto bus and reports bus level.
// - Transmit high leaves drivers off; transmit low turns drivers on.
// - Listen-only reports bus level, drivers off, transmit pulled high.
// - Low-power entry forces sleep with wake-up unless mode is sleep 00.
// - Asleep in low-power: driver, receiver off, bus and pins pulled low.
// - Leaving low-power restores the mode held just before entry.
// - Transmit stuck low: drivers off, receiver on, mode MSB cleared, flag.
// - After transmit fault, recover on normal mode and txd high; thermal fault as below.
// - Transmit, receive and bus-dominant monitors run only in normal/listen.
// - Seven recessive samples: drivers, receiver off, MSB cleared, flag.
// - Low line below 0.5 V five times at sample point reports short.
// - High line above 5.2 V five times at sample point reports short.
// - Line current above 75 mA five times at sample point reports short.
// - Line shorts are only reported; driver and receiver stay enabled.
// - Bus dominant too long sets flag, driver stays enabled.
// - Overtemperature: drivers off, receiver on, MSB cleared, flag set.
// - Drivers stay off until cool and a transmit falling edge.
// - Error flags interrupt unless masked or inhibited; diagnostics never interrupt.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
module ctf_ctrl #(
  parameter int TXD_TO_CYC = ctf_pkg::TXD_DOM_TIMEOUT_CYC,
  parameter int BUS_TO_CYC = ctf_pkg::BUS_DOM_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic txd_i,
  input wire logic bus_dom_i,
  input wire logic canl_low_i,
  input wire logic canh_high_i,
  input wire logic line_overcur_i,
  input wire logic overtemp_i,
  input wire logic temp_cool_i,
  input wire logic low_power_off_mode_i,
  output logic rxd_o,
  output logic bus_drive_o,
  output logic receiver_en_o,
  output logic bus_pulldown_o,
  output logic txd_pullup_o,
  output logic txd_pulldown_o,
  output logic irq_o
);
  import ctf_pkg::*;

  typedef enum {LP_AWAKE, LP_OFF} ctf_lp_state_t;

  localparam int TW = $clog2(TXD_TO_CYC + 1);
  localparam int BW = $clog2(BUS_TO_CYC + 1);
  localparam int SW = $clog2(SHORT_SAMPLE_CYC + 1);

  logic [IN_N-1:0] sync1, sync2;
  logic txd_s, bus_dom_s, ot_s, cool_s, txd_prev, ot_prev, txd_fall;
  ctf_lp_state_t lp_state;
  logic lp_enter, lp_exit, inhibit;
  logic [1:0] mode, saved_mode;
  logic [ERR_N-1:0] err_status, err_mask, err_ev;
  logic [DIAG_N-1:0] diag, short_hit, short_ev;
  logic txd_lock, ot_lock, rx_lock, mon_en, drv_path, rcv_on;
  logic [TW-1:0] txd_cnt;
  logic [BW-1:0] bus_cnt;
  logic [SW-1:0] smp_cnt;
  logic smp_pulse, txd_to_ev, bus_dom_ev, rx_ev, ot_ev, fault_ev;
  logic acc, wr, wr_ctrl;

  // Pins and analog comparators come from outside this clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= SYNC_RESET;
      sync2 <= SYNC_RESET;
      txd_prev <= 1'b1;
      ot_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {temp_cool_i, overtemp_i, line_overcur_i, canh_high_i,
                canl_low_i, bus_dom_i, txd_i};
      sync2 <= sync1;
      txd_prev <= txd_s;
      ot_prev <= ot_s;
    end
  end

  assign txd_s = sync2[IN_TXD];
  assign bus_dom_s = sync2[IN_BUS_DOM];
  assign ot_s = sync2[IN_OT];
  assign cool_s = sync2[IN_COOL];
  assign txd_fall = txd_prev && !txd_s;

  // Wishbone slave: ack one cycle after the strobe, write at the ack edge
  assign acc = wb_cyc_i && wb_stb_i;
  assign wr = acc && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign wr_ctrl = wr && (wb_adr_i == ADDR_CTRL);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= acc && !wb_ack_o;
      if (acc && !wb_ack_o)
      begin
        case (wb_adr_i)
          ADDR_CTRL: wb_dat_o <= {29'h0, inhibit, mode};
          ADDR_STATUS: wb_dat_o <= {28'h0, err_status};
          ADDR_MASK: wb_dat_o <= {28'h0, err_mask};
          ADDR_DIAG: wb_dat_o <= {29'h0, diag};
          ADDR_STATE: wb_dat_o <= {26'h0, lp_state == LP_OFF, rcv_on,
                                   drv_path, rx_lock, ot_lock, txd_lock};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // Low-power tracker
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lp_state <= LP_AWAKE;
    else
    begin
      case (lp_state)
        LP_AWAKE: if (low_power_off_mode_i) lp_state <= LP_OFF;
        LP_OFF: if (!low_power_off_mode_i) lp_state <= LP_AWAKE;
        default: lp_state <= LP_AWAKE;
      endcase
    end
  end

  assign lp_enter = (lp_state == LP_AWAKE) && low_power_off_mode_i;
  assign lp_exit = (lp_state == LP_OFF) && !low_power_off_mode_i;

  // Later assignments win: low-power entry over host write, fault last
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode <= MODE_RESET;
      saved_mode <= MODE_RESET;
      inhibit <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode <= wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB];
        inhibit <= wb_dat_i[CTRL_INHIBIT];
      end
      if (lp_enter)
      begin
        saved_mode <= mode;
        if (mode != MODE_SLEEP)
          mode <= MODE_SLEEP_WU;
      end
      if (lp_exit)
        mode <= saved_mode;
      if (fault_ev)
        mode[CTRL_MODE_MSB] <= 1'b0;
    end
  end

  // Normal and listen-only are exactly the modes with the LSB set
  assign mon_en = mode[CTRL_MODE_LSB] && (lp_state == LP_AWAKE);
  assign drv_path = (mode == MODE_NORMAL) && (lp_state == LP_AWAKE)
                    && !txd_lock && !ot_lock && !rx_lock;
  assign rcv_on = mon_en && !rx_lock;

  // Timeouts saturate so each stuck episode fires once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !mon_en || txd_s)
      txd_cnt <= '0;
    else if (txd_cnt != TW'(TXD_TO_CYC))
      txd_cnt <= txd_cnt + TW'(1);
  end

  assign txd_to_ev = mon_en && !txd_s
                     && (txd_cnt == TW'(TXD_TO_CYC - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !mon_en || !bus_dom_s)
      bus_cnt <= '0;
    else if (bus_cnt != BW'(BUS_TO_CYC))
      bus_cnt <= bus_cnt + BW'(1);
  end

  assign bus_dom_ev = mon_en && bus_dom_s
                      && (bus_cnt == BW'(BUS_TO_CYC - 1));

  // Sample point a fixed delay after transmit goes low
  always_ff @(posedge clk_i)
  begin
    if (rst_i || txd_s)
      smp_cnt <= '0;
    else if (smp_cnt != SW'(SHORT_SAMPLE_CYC))
      smp_cnt <= smp_cnt + SW'(1);
  end

  // Only meaningful while this node is actually driving dominant
  assign smp_pulse = drv_path && !txd_s
                     && (smp_cnt == SW'(SHORT_SAMPLE_CYC - 1));

  assign short_hit = {sync2[IN_OVERCUR], sync2[IN_CANH_HIGH],
                      sync2[IN_CANL_LOW]};

  genvar gi;
  generate
    for (gi = 0; gi < DIAG_N; gi++)
    begin : g_short
      ctf_streak #(
        .N(SHORT_STREAK)
      ) u_short (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(!drv_path),
        .sample_i(smp_pulse),
        .hit_i(short_hit[gi]),
        .detect_o(short_ev[gi])
      );
    end
  endgenerate

  // Driven dominant but the bus still reads recessive
  ctf_streak #(
    .N(RX_REC_STREAK)
  ) u_rx_rec (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!mon_en),
    .sample_i(smp_pulse),
    .hit_i(!bus_dom_s),
    .detect_o(rx_ev)
  );

  // Sleep modes must not be degraded by heat, so watch only active modes
  assign ot_ev = ot_s && !ot_prev && mon_en;
  assign fault_ev = txd_to_ev || rx_ev || ot_ev;

  // Set wins over the recovery condition
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txd_lock <= 1'b0;
      ot_lock <= 1'b0;
      rx_lock <= 1'b0;
    end
    else
    begin
      if (txd_to_ev)
        txd_lock <= 1'b1;
      else if (mode == MODE_NORMAL && txd_s)
        txd_lock <= 1'b0;
      if (ot_ev)
        ot_lock <= 1'b1;
      else if (mode == MODE_NORMAL && cool_s && !ot_s && txd_fall)
        ot_lock <= 1'b0;
      if (rx_ev)
        rx_lock <= 1'b1;
      else if (wr_ctrl
               && wb_dat_i[CTRL_MODE_MSB:CTRL_MODE_LSB] == MODE_NORMAL)
        rx_lock <= 1'b0;
    end
  end

  assign err_ev = {ot_ev, bus_dom_ev, rx_ev, txd_to_ev};

  // Sticky flags, write one to clear, a new event beats the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      err_status <= '0;
      err_mask <= MASK_RESET;
      diag <= '0;
    end
    else
    begin
      err_status <= (err_status & ~((wr && wb_adr_i == ADDR_STATUS) ?
                     wb_dat_i[ERR_N-1:0] : '0)) | err_ev;
      diag <= (diag & ~((wr && wb_adr_i == ADDR_DIAG) ?
               wb_dat_i[DIAG_N-1:0] : '0)) | short_ev;
      if (wr && wb_adr_i == ADDR_MASK)
        err_mask <= wb_dat_i[ERR_N-1:0];
    end
  end

  // Pin outputs; shorts never reach these terms
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_drive_o <= 1'b0;
      receiver_en_o <= 1'b0;
      rxd_o <= 1'b1;
      bus_pulldown_o <= 1'b0;
      txd_pullup_o <= 1'b0;
      txd_pulldown_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      bus_drive_o <= drv_path && !txd_s;
      receiver_en_o <= rcv_on;
      if (lp_state == LP_OFF)
        rxd_o <= 1'b0;
      else
        rxd_o <= !(rcv_on && bus_dom_s);
      bus_pulldown_o <= lp_state == LP_OFF;
      txd_pulldown_o <= lp_state == LP_OFF;
      txd_pullup_o <= (mode == MODE_LISTEN)
                      && (lp_state == LP_AWAKE);
      irq_o <= |(err_status & err_mask) && !inhibit;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // The event is gone one cycle later, so look back at what fired
  property p_fault_msb;
    fault_ev |=> !mode[CTRL_MODE_MSB]
                 && ((err_status & $past(err_ev)) != '0);
  endproperty
  a_fault_msb: assert property (p_fault_msb)
    else $error("fault did not clear mode MSB and flag");
  property p_normal_demote;
    (mode == MODE_NORMAL && fault_ev && !wr_ctrl && !lp_enter)
      |=> mode == MODE_LISTEN;
  endproperty
  a_normal_demote: assert property (p_normal_demote)
    else $error("faulted normal mode did not read listen-only");
  property p_drive_follows_txd;
    drv_path && !txd_s |=> bus_drive_o ##0 receiver_en_o;
  endproperty
  a_drive_follows_txd: assert property (p_drive_follows_txd)
    else $error("normal mode did not drive dominant on low txd");
  property p_listen_quiet;
    (mode == MODE_LISTEN && lp_state == LP_AWAKE)
      |=> !bus_drive_o && txd_pullup_o;
  endproperty
  a_listen_quiet: assert property (p_listen_quiet)
    else $error("listen-only mode drove the bus");
  property p_lp_entry;
    lp_enter && !fault_ev |=>
      mode == (($past(mode) == MODE_SLEEP) ? MODE_SLEEP : MODE_SLEEP_WU);
  endproperty
  a_lp_entry: assert property (p_lp_entry)
    else $error("wrong mode on low-power entry");
  property p_lp_pins;
    lp_state == LP_OFF |=> !rxd_o && bus_pulldown_o && txd_pulldown_o
                           && !receiver_en_o && !bus_drive_o;
  endproperty
  a_lp_pins: assert property (p_lp_pins)
    else $error("sleep pins not pulled low");
  property p_lp_restore;
    lp_exit |=> mode == $past(saved_mode);
  endproperty
  a_lp_restore: assert property (p_lp_restore)
    else $error("mode not restored after low power");
  property p_monitors_idle;
    !mon_en |-> !txd_to_ev && !bus_dom_ev && !rx_ev;
  endproperty
  a_monitors_idle: assert property (p_monitors_idle)
    else $error("monitor fired outside normal or listen-only");
  property p_ot_hold;
    ot_lock && !cool_s |=> ot_lock ##1 !bus_drive_o;
  endproperty
  a_ot_hold: assert property (p_ot_hold)
    else $error("drivers re-enabled while still hot");
  property p_diag_no_irq;
    (err_status == '0) && (diag != '0) |=> !irq_o;
  endproperty
  a_diag_no_irq: assert property (p_diag_no_irq)
    else $error("diagnostic flag raised the interrupt");
  c_lp_cycle: cover property (lp_enter ##[1:20] lp_exit);
  c_rx_rec: cover property (rx_ev);
  c_ot_recover: cover property (ot_lock ##1 !ot_lock);
  c_short: cover property (|short_ev);
endmodule

/* File: ctf_pkg.sv */
package ctf_pkg;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_LISTEN = 2'h1;
  localparam logic [1:0] MODE_SLEEP_WU = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_NORMAL;

  localparam int CLK_PERIOD_NS = 25;
  localparam int SHORT_SAMPLE_NS = 500;
  localparam int SHORT_SAMPLE_CYC =
    (SHORT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_STREAK = 5;
  localparam int RX_REC_STREAK = 7;
  localparam int TXD_DOM_TIMEOUT_US = 1000;
  localparam int BUS_DOM_TIMEOUT_US = 1000;
  localparam int TXD_DOM_TIMEOUT_CYC =
    (TXD_DOM_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_DOM_TIMEOUT_CYC =
    (BUS_DOM_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_DIAG = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 1;
  localparam int CTRL_INHIBIT = 2;
  localparam int ERR_N = 4;
  localparam int ERR_TXD_DOM = 0;
  localparam int ERR_RX_REC = 1;
  localparam int ERR_BUS_DOM = 2;
  localparam int ERR_OT = 3;
  localparam int DIAG_N = 3;
  localparam logic [ERR_N-1:0] MASK_RESET = 4'hF;

  localparam int IN_N = 7;
  localparam int IN_TXD = 0;
  localparam int IN_BUS_DOM = 1;
  localparam int IN_CANL_LOW = 2;
  localparam int IN_CANH_HIGH = 3;
  localparam int IN_OVERCUR = 4;
  localparam int IN_OT = 5;
  localparam int IN_COOL = 6;
  localparam logic [IN_N-1:0] SYNC_RESET = 7'h41;
endpackage

/* File: ctf_streak.sv */
module ctf_streak #(
  parameter int N = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic sample_i,
  input wire logic hit_i,
  output logic detect_o
);
  import ctf_pkg::*;
  localparam int W = $clog2(N + 1);
  logic [W-1:0] cnt;

  // A miss restarts the run, so only back-to-back hits count
  assign detect_o = sample_i && hit_i && (cnt == W'(N - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      cnt <= '0;
    else if (sample_i)
    begin
      if (!hit_i || detect_o)
        cnt <= '0;
      else
        cnt <= cnt + W'(1);
    end
  end

  property p_streak_restart;
    @(posedge clk_i) disable iff (rst_i)
    (sample_i && !hit_i && !clear_i) |=> (cnt == '0);
  endproperty
  a_streak_restart: assert property (p_streak_restart)
    else $error("streak count not restarted by a miss");
endmodule

/* File: ctf_host_ctrl.sv */
module ctf_host_ctrl (
  input wire logic clk_i,
  input wire logic bus_drive_i,
  input wire logic stuck_rec_i,
  input wire logic other_dom_i,
  output logic txd_o,
  output logic bus_dom_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial txd_o = 1'h1;
  // Wired bus seen by the receiver; a broken path reads recessive
  assign bus_dom_o = !stuck_rec_i && (bus_drive_i || other_dom_i);
  task automatic set_txd(input logic v);
    @(posedge clk_i);
    txd_o <= v;
  endtask
  // Frames kept short of the transmit timeout
  task automatic frames(input int n, input int lo);
    repeat (n)
    begin
      set_txd(1'h0);
      repeat (lo) @(posedge clk_i);
      set_txd(1'h1);
      repeat (10) @(posedge clk_i);
    end
  endtask
endmodule

/* File: can_transceiver_mode_fault_ctrl_bench.sv */
module can_transceiver_mode_fault_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ctf_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, low_power_off_mode, hot, cool, stuck, odom;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [2:0] sc;
  logic [3:0] sel;
  logic ack, rxd, drv, rxen, bpd, tpu, tpd, irq, txd, bdom;
  int error_cnt, check_count;
  ctf_ctrl #(.TXD_TO_CYC(50), .BUS_TO_CYC(80)) ctf_ctrl_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .txd_i(txd),
    .bus_dom_i(bdom),
    .canl_low_i(sc[0]),
    .canh_high_i(sc[1]),
    .line_overcur_i(sc[2]),
    .overtemp_i(hot),
    .temp_cool_i(cool),
    .low_power_off_mode_i(low_power_off_mode),
    .rxd_o(rxd),
    .bus_drive_o(drv),
    .receiver_en_o(rxen),
    .bus_pulldown_o(bpd),
    .txd_pullup_o(tpu),
    .txd_pulldown_o(tpd),
    .irq_o(irq)
  );
  ctf_host_ctrl host (
    .clk_i(clk_i),
    .bus_drive_i(drv),
    .stuck_rec_i(stuck),
    .other_dom_i(odom),
    .txd_o(txd),
    .bus_dom_o(bdom)
  );
  initial
  begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic cw(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20)
    begin
      error_cnt++;
      $display("mismatch ack expected 1 seen timeout");
      test_done();
    end
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic t_reset();
    chk("rxd", 1'h1, rxd);
    rd("ctrl", ADDR_CTRL, 32'h3);
    rd("mask", ADDR_MASK, 32'hF);
    rd("status", ADDR_STATUS, 32'h0);
    rd("unmapped", 8'h20, 32'h0);
    // Fields sit in byte 0, so a write without that lane must be ignored
    sel <= 4'hE;
    wb(1'h1, ADDR_CTRL, 32'h1);
    sel <= 4'hF;
    rd("ctrl no lane", ADDR_CTRL, 32'h3);
  endtask
  task automatic t_normal();
    // The bus level returns through two more sync stages before rxd
    host.set_txd(1'h0);
    cw(8);
    chk("drive", 1'h1, drv);
    chk("rxd", 1'h0, rxd);
    host.set_txd(1'h1);
    cw(8);
    chk("drive", 1'h0, drv);
    chk("rxd", 1'h1, rxd);
  endtask
  task automatic t_listen();
    wb(1'h1, ADDR_CTRL, 32'h1);
    host.set_txd(1'h0);
    cw(5);
    chk("drive", 1'h0, drv);
    chk("pullup", 1'h1, tpu);
    host.set_txd(1'h1);
    odom <= 1'h1;
    cw(5);
    chk("rxd", 1'h0, rxd);
    odom <= 1'h0;
    wb(1'h1, ADDR_CTRL, 32'h3);
  endtask
  task automatic t_low_power_off_mode();
    for (int m = 0; m < 4; m++)
    begin
      wb(1'h1, ADDR_CTRL, m);
      low_power_off_mode <= 1'h1;
      cw(3);
      rd("ctrl", ADDR_CTRL, (m == 0) ? 32'h0 : 32'h2);
      chk("pins", 4'hC, {bpd, tpd, rxen, rxd});
      low_power_off_mode <= 1'h0;
      cw(3);
      rd("ctrl", ADDR_CTRL, m);
    end
  endtask
  task automatic t_txd();
    host.set_txd(1'h0);
    cw(60);
    chk("drv rxen", 2'h1, {drv, rxen});
    rd("ctrl", ADDR_CTRL, 32'h1);
    rd("status", ADDR_STATUS, 32'h1);
    chk("irq", 1'h1, irq);
    // Normal mode rewritten while txd still low: drivers must stay off
    wb(1'h1, ADDR_CTRL, 32'h3);
    cw(3);
    chk("drive", 1'h0, drv);
    host.set_txd(1'h1);
    cw(4);
    host.set_txd(1'h0);
    cw(5);
    chk("drive", 1'h1, drv);
    host.set_txd(1'h1);
    wb(1'h1, ADDR_STATUS, 32'h1);
    cw(3);
    chk("irq", 1'h0, irq);
  endtask
  task automatic t_bus_irq();
    wb(1'h1, ADDR_CTRL, 32'h7);
    odom <= 1'h1;
    cw(100);
    odom <= 1'h0;
    rd("status", ADDR_STATUS, 32'h4);
    chk("irq", 1'h0, irq);
    host.set_txd(1'h0);
    cw(5);
    chk("drive", 1'h1, drv);
    host.set_txd(1'h1);
    wb(1'h1, ADDR_CTRL, 32'h3);
    cw(3);
    chk("irq", 1'h1, irq);
    wb(1'h1, ADDR_MASK, 32'hB);
    cw(3);
    chk("irq", 1'h0, irq);
    wb(1'h1, ADDR_MASK, 32'hF);
    wb(1'h1, ADDR_STATUS, 32'h4);
    cw(3);
    chk("irq", 1'h0, irq);
  endtask
  task automatic t_rx();
    stuck <= 1'h1;
    host.frames(7, 30);
    stuck <= 1'h0;
    rd("status", ADDR_STATUS, 32'h2);
    rd("ctrl", ADDR_CTRL, 32'h1);
    chk("rxen", 1'h0, rxen);
    wb(1'h1, ADDR_CTRL, 32'h3);
    wb(1'h1, ADDR_STATUS, 32'hF);
    cw(3);
    chk("rxen", 1'h1, rxen);
  endtask
  task automatic t_short();
    for (int k = 0; k < 3; k++)
    begin
      sc <= 3'h1 << k;
      host.frames(5, 30);
      sc <= 3'h0;
      rd("diag", ADDR_DIAG, 32'h1 << k);
      chk("irq", 1'h0, irq);
      rd("state", ADDR_STATE, 32'h18);
      wb(1'h1, ADDR_DIAG, 32'h7);
    end
  endtask
  task automatic t_ot();
    hot <= 1'h1;
    cool <= 1'h0;
    cw(6);
    rd("status", ADDR_STATUS, 32'h8);
    rd("ctrl", ADDR_CTRL, 32'h1);
    chk("rxen", 1'h1, rxen);
    hot <= 1'h0;
    wb(1'h1, ADDR_CTRL, 32'h3);
    host.set_txd(1'h0);
    cw(5);
    chk("drive", 1'h0, drv);
    host.set_txd(1'h1);
    cool <= 1'h1;
    cw(5);
    host.set_txd(1'h0);
    cw(5);
    chk("drive", 1'h1, drv);
    host.set_txd(1'h1);
    wb(1'h1, ADDR_STATUS, 32'hF);
  endtask
  task automatic t_sleep_mon();
    wb(1'h1, ADDR_CTRL, 32'h0);
    host.set_txd(1'h0);
    cw(60);
    host.set_txd(1'h1);
    rd("status", ADDR_STATUS, 32'h0);
    rd("ctrl", ADDR_CTRL, 32'h0);
    wb(1'h1, ADDR_CTRL, 32'h3);
  endtask
  initial
  begin
    rst_i = 1'h1;
    {cyc, stb, we, low_power_off_mode, hot, stuck, odom} = 7'h0;
    cool = 1'h1;
    adr = 8'h0;
    dat = 32'h0;
    sc = 3'h0;
    sel = 4'hF;
    error_cnt = 0;
    check_count = 0;
    cw(4);
    rst_i <= 1'h0;
    cw(3);
    t_reset();
    t_normal();
    t_listen();
    t_low_power_off_mode();
    t_txd();
    t_bus_irq();
    t_rx();
    t_short();
    t_ot();
    t_sleep_mon();
    test_done();
  end
endmodule
